// *** src/fam_pkg.sv ***
package fam_pkg;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_NS = 1_000_000;
  localparam int TICK_CYC = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RETRY_INTERVAL_MS = 5;
  localparam int RUN_CLEAR_MIN = 10;
  localparam int RUN_CLEAR_MS = RUN_CLEAR_MIN * 60 * 1000;
  localparam int FAN_PERIOD_S = 60;
  localparam int FAN_STOP_S = 3;
  localparam int FAN_PERIOD_MS = FAN_PERIOD_S * 1000;
  localparam int FAN_STOP_MS = FAN_STOP_S * 1000;
  localparam int BLINK_HALF_MS = 500;

  // ************************************************************
  // parameter register map
  // ************************************************************
  localparam logic [15:0] OFS_RESTART_LIMIT = 16'h049E;
  localparam logic [15:0] OFS_RESTART_FC_SEL = 16'h049F;
  localparam logic [15:0] OFS_FAN_DETECT_SEL = 16'h04E2;
  localparam logic [15:0] OFS_RESTART_STATUS = 16'h04F0;
  localparam logic [15:0] RST_RESTART_LIMIT = 16'h0000;
  localparam logic [15:0] RST_RESTART_FC_SEL = 16'h0000;
  localparam logic [15:0] RST_FAN_DETECT_SEL = 16'h0001;
  localparam logic [15:0] RESTART_LIMIT_MAX = 16'h000A;

  // ************************************************************
  // trip vector bit positions
  // ************************************************************
  localparam int TRIP_W = 16;
  localparam int TRIP_BUS_UNDERVOLTAGE = 4;
  localparam int TRIP_MOTOR_OVERHEAT = 11;
  localparam logic [15:0] TRIP_RESTARTABLE = 16'h3FFF;

  // ************************************************************
  // contact functions, ratings, overload figures
  // ************************************************************
  localparam logic [7:0] FUNC_MINOR_FAULT = 8'h10;
  localparam logic [7:0] FUNC_RESTART_EN = 8'h1E;
  localparam logic [7:0] FUNC_FAN_FAULT = 8'h3D;
  localparam logic [7:0] RATING_NORMAL_PCT = 8'h64;
  localparam logic [7:0] RATING_DERATED_PCT = 8'h50;
  localparam logic [7:0] CT_FAN_BASE_S = 8'hB4;
  localparam logic [7:0] CT_FAN_PEAK_PCT = 8'h96;
  localparam logic [7:0] CT_FAN_PEAK_S = 8'h0F;
  localparam logic [7:0] VT_FAN_BASE_S = 8'h1E;
  localparam logic [7:0] VT_FAN_PEAK_PCT = 8'h78;
  localparam logic [7:0] VT_FAN_PEAK_S = 8'h0A;

  typedef enum logic [2:0] {
    FAM_ST_RUN, FAM_ST_BASEBLOCK, FAM_ST_RETRY, FAM_ST_CHECK, FAM_ST_PROTECT
  } fam_state_e;

endpackage

// *** src/fam_ms_tick.sv ***
`timescale 1ns/1ps
`default_nettype none
module fam_ms_tick import fam_pkg::*; #(
  parameter int CYC = TICK_CYC
) (
  input wire logic i_clock, // control clock
  input wire logic i_rstn,  // async reset, active low
  output logic o_tick       // one-cycle pulse each millisecond
);
  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } fam_tick_s;
  fam_tick_s tick_ff;
  fam_tick_s nxt_tick;

  // free-running prescaler, all slow timers share it
  always_comb begin
    nxt_tick = tick_ff;
    nxt_tick.tick = (tick_ff.cnt == 32'(CYC - 1));
    nxt_tick.cnt = nxt_tick.tick ? 32'h00000000 : tick_ff.cnt + 32'h00000001;
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      tick_ff <= '0;
    end else begin
      tick_ff <= nxt_tick;
    end
  end

  assign o_tick = tick_ff.tick;
endmodule
`default_nettype wire

// *** src/fam_fan_cycler.sv ***
`timescale 1ns/1ps
`default_nettype none
module fam_fan_cycler import fam_pkg::*; #(
  parameter int PERIOD_MS = FAN_PERIOD_MS,
  parameter int STOP_MS = FAN_STOP_MS,
  parameter int BLINK_MS = BLINK_HALF_MS
) (
  input wire logic i_clock,     // control clock
  input wire logic i_rstn,      // async reset, active low
  input wire logic i_tick,      // millisecond tick
  input wire logic i_fan_fault, // synchronised fan fault level
  output logic o_fan_run,       // fan drive, high = running
  output logic o_blink          // warning blink phase
);
  typedef struct packed {
    logic [31:0] per;
    logic [31:0] blk;
    logic run;
    logic blink;
  } fam_fan_s;
  fam_fan_s fan_ff;
  fam_fan_s nxt_fan;

  // interval operation: stopped for the first STOP_MS of every period
  always_comb begin
    nxt_fan = fan_ff;
    if (!i_fan_fault) begin
      nxt_fan = '0;
      nxt_fan.run = 1'b1;
    end else if (i_tick) begin
      nxt_fan.per = (fan_ff.per == 32'(PERIOD_MS - 1)) ? 32'h00000000 : fan_ff.per + 32'h00000001;
      nxt_fan.run = (nxt_fan.per >= 32'(STOP_MS)); // [RULE18]
      nxt_fan.blk = (fan_ff.blk == 32'(BLINK_MS - 1)) ? 32'h00000000 : fan_ff.blk + 32'h00000001;
      if (fan_ff.blk == 32'(BLINK_MS - 1)) begin
        nxt_fan.blink = ~fan_ff.blink;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      fan_ff <= '{per: 32'h00000000, blk: 32'h00000000, run: 1'b1, blink: 1'b0};
    end else begin
      fan_ff <= nxt_fan;
    end
  end

  assign o_fan_run = fan_ff.run;
  assign o_blink = fan_ff.blink;
endmodule
`default_nettype wire

// *** src/fam_restart_mgr.sv ***
// Notes on behaviour
// [RULE1] trip while running: self-check, then restart through speed search if clean
// [RULE2] after minimum baseblock time, attempt a fault clear every 5 ms
// [RULE3] restart count increments on each successful clear-and-resume
// [RULE4] attempt limit 0..10, default 0; beyond it the normal protective trip occurs
// [RULE5] only the fourteen listed trip types restart; any other trip protects
// [RULE6] undervoltage restarts only when ride-through select is 1 or 2
// [RULE7] contact output coded 1E shows restart enabled
// [RULE8] restart contact select: 1 activates fault contact during restart, 0 not
// [RULE9] count clears after ten minutes of uninterrupted running after a restart
// [RULE10] count clears on fault reset after an acknowledged protective trip
// [RULE11] count is zero after power-up reset
// [RULE12] fan select 0 gives minor warning, 1 gives motor-overheat trip, coasting
// [RULE13] select 0 fan fault: keep running, blink warning, minor fault contact
// [RULE14] select 0 fan fault while running: rated current limited to 80 percent
// [RULE15] constant torque fan fault: 100 percent per 3 min, 150 percent per 15 s
// [RULE16] variable torque fan fault: 100 percent per 30 s, 120 percent per 10 s
// [RULE17] with select 0, software sets a contact to code 10 or 3D
// [RULE18] during fan fault the fan stops about 3 s in every minute
// [RULE19] speed search starts from the frequency running at the trip
// [RULE20] a new trip restarts the ten-minute running timer from zero
`timescale 1ns/1ps
`default_nettype none
module fam_restart_mgr import fam_pkg::*; #(
  parameter int N_OUT = 5,
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int RUN_CLEAR_TICKS = RUN_CLEAR_MS,
  parameter int FAN_PERIOD_TICKS = FAN_PERIOD_MS,
  parameter int FAN_STOP_TICKS = FAN_STOP_MS,
  parameter logic [7:0] NORM_BASE_S = 8'h3C,
  parameter logic [7:0] NORM_PEAK_PCT = 8'h96,
  parameter logic [7:0] NORM_PEAK_S = 8'h3C
) (
  input wire logic i_clock,                    // control clock, 125 MHz
  input wire logic i_rstn,                     // power-up reset, active low
  input wire logic [15:0] i_reg_addr,          // parameter register number
  input wire logic i_reg_wr,                   // parameter write strobe
  input wire logic i_reg_rd,                   // parameter read strobe
  input wire logic [15:0] i_reg_wdata,         // write data
  output logic [15:0] o_reg_rdata,             // read data
  output logic o_reg_ack,                      // access done pulse
  input wire logic [TRIP_W-1:0] i_trip_vec,    // trip detector levels
  input wire logic i_running,                  // drive is in run
  input wire logic i_self_check_ok,            // self-diagnosis found nothing
  input wire logic [15:0] i_run_freq,          // present output frequency
  input wire logic [15:0] i_min_baseblock_ms,  // minimum baseblock time
  input wire logic [1:0] i_ride_through_sel,   // power loss ride-through select
  input wire logic i_variable_torque,          // 1 = variable torque duty
  input wire logic [N_OUT*8-1:0] i_contact_func, // contact function codes
  input wire logic i_fault_reset,              // fault reset terminal (pin)
  input wire logic i_fan_fault,                // cooling fan fault (pin)
  output logic o_coast_stop,                   // gate block, motor coasts
  output logic o_fault_clear,                  // fault clear pulse
  output logic o_search_start,                 // speed search start pulse
  output logic [15:0] o_search_freq,           // search start frequency
  output logic o_restart_active,               // auto restart in progress
  output logic o_fault_contact,                // fault contact
  output logic o_minor_fault,                  // minor fault indication
  output logic o_fan_warn_blink,               // fan warning display phase
  output logic o_fan_run,                      // cooling fan drive
  output logic [7:0] o_rating_pct,             // rated current limit
  output logic [7:0] o_ovl_base_s,             // 100 percent overload window
  output logic [7:0] o_ovl_peak_pct,           // peak overload level
  output logic [7:0] o_ovl_peak_s,             // peak overload window
  output logic [N_OUT-1:0] o_contacts,         // programmable contacts
  output logic [3:0] o_restart_count           // restarts so far
);
  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    fam_state_e state;
    logic rst_s1;
    logic rst_s2;
    logic rst_s3;
    logic fan_s1;
    logic fan_s2;
    logic [15:0] tmr;
    logic [31:0] run_tmr;
    logic [3:0] count;
    logic restarted;
    logic [15:0] limit;
    logic [15:0] fc_sel;
    logic [15:0] fan_sel;
    logic [15:0] rdata;
    logic ack;
    logic clear_p;
    logic search_p;
    logic [15:0] freq;
    logic coast;
    logic fault_ct;
    logic minor;
    logic restart_act;
    logic [7:0] rating;
    logic [7:0] ovl_base;
    logic [7:0] ovl_pct;
    logic [7:0] ovl_peak;
    logic [N_OUT-1:0] contacts;
  } fam_mgr_s;
  fam_mgr_s st_ff;
  fam_mgr_s nxt_st;

  logic tick;
  logic fan_run;
  logic blink;
  logic [N_OUT-1:0] nxt_contacts;
  logic [TRIP_W-1:0] trip_eff;
  logic [TRIP_W-1:0] elig_mask;
  logic fan_major;
  logic trip_any;
  logic restartable;
  logic reset_edge;

  fam_ms_tick #(.CYC(TICK_CYCLES)) u_tick (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .o_tick(tick)
  );

  fam_fan_cycler #(.PERIOD_MS(FAN_PERIOD_TICKS), .STOP_MS(FAN_STOP_TICKS)) u_fan (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_tick(tick),
    .i_fan_fault(st_ff.fan_s2),
    .o_fan_run(fan_run),
    .o_blink(blink)
  );

  // ************************************************************
  // trip classification
  // ************************************************************
  // fan fault with select 1 becomes a motor overheat trip
  assign fan_major = st_ff.fan_s2 & st_ff.fan_sel[0]; // [RULE12]
  assign trip_eff = i_trip_vec | (TRIP_W'(fan_major) << TRIP_MOTOR_OVERHEAT);
  assign trip_any = |trip_eff;
  // undervoltage joins the set only under ride-through 1 or 2
  always_comb begin
    elig_mask = TRIP_RESTARTABLE; // [RULE5]
    if (i_ride_through_sel != 2'h1 && i_ride_through_sel != 2'h2) begin
      elig_mask[TRIP_BUS_UNDERVOLTAGE] = 1'b0; // [RULE6]
    end
  end
  // any trip outside the set forces protection even if another is in it
  assign restartable = trip_any && ((trip_eff & ~elig_mask) == '0); // [RULE5]
  assign reset_edge = st_ff.rst_s2 & ~st_ff.rst_s3;

  // ************************************************************
  // contact outputs, one per programmable terminal
  // ************************************************************
  for (genvar k = 0; k < N_OUT; k++) begin : g_contact
    logic [7:0] func;
    assign func = i_contact_func[k*8 +: 8];
    always_comb begin
      nxt_contacts[k] = 1'b0;
      if (func == FUNC_RESTART_EN) begin
        nxt_contacts[k] = nxt_st.restart_act; // [RULE7]
      end else if (func == FUNC_MINOR_FAULT || func == FUNC_FAN_FAULT) begin
        nxt_contacts[k] = nxt_st.minor; // [RULE13]
      end
    end
  end

  // ************************************************************
  // sequencer and register port
  // ************************************************************
  always_comb begin
    nxt_st = st_ff;
    // two-stage synchronisers, third stage only for the reset edge
    nxt_st.rst_s1 = i_fault_reset;
    nxt_st.rst_s2 = st_ff.rst_s1;
    nxt_st.rst_s3 = st_ff.rst_s2;
    nxt_st.fan_s1 = i_fan_fault;
    nxt_st.fan_s2 = st_ff.fan_s1;
    nxt_st.clear_p = 1'b0;
    nxt_st.search_p = 1'b0;
    nxt_st.ack = i_reg_wr | i_reg_rd;

    // parameter writes; limit clamps so an odd value cannot disable protection
    if (i_reg_wr) begin
      if (i_reg_addr == OFS_RESTART_LIMIT) begin
        nxt_st.limit = (i_reg_wdata > RESTART_LIMIT_MAX) ? RESTART_LIMIT_MAX : i_reg_wdata; // [RULE4]
      end else if (i_reg_addr == OFS_RESTART_FC_SEL) begin
        nxt_st.fc_sel = {15'h0000, i_reg_wdata[0]};
      end else if (i_reg_addr == OFS_FAN_DETECT_SEL) begin
        nxt_st.fan_sel = {15'h0000, i_reg_wdata[0]};
      end
    end
    nxt_st.rdata = 16'h0000;
    if (i_reg_rd) begin
      if (i_reg_addr == OFS_RESTART_LIMIT) begin
        nxt_st.rdata = st_ff.limit;
      end else if (i_reg_addr == OFS_RESTART_FC_SEL) begin
        nxt_st.rdata = st_ff.fc_sel;
      end else if (i_reg_addr == OFS_FAN_DETECT_SEL) begin
        nxt_st.rdata = st_ff.fan_sel;
      end else if (i_reg_addr == OFS_RESTART_STATUS) begin
        nxt_st.rdata = {8'h00, 3'h0, st_ff.restart_act, st_ff.count};
      end
    end

    case (st_ff.state)
      FAM_ST_RUN: begin
        // uninterrupted running after a restart clears the count
        if (st_ff.restarted && i_running && !trip_any && tick) begin
          if (st_ff.run_tmr == 32'(RUN_CLEAR_TICKS - 1)) begin
            nxt_st.count = 4'h0; // [RULE9]
            nxt_st.restarted = 1'b0;
            nxt_st.run_tmr = 32'h00000000;
          end else begin
            nxt_st.run_tmr = st_ff.run_tmr + 32'h00000001;
          end
        end
        if (trip_any) begin
          nxt_st.run_tmr = 32'h00000000; // [RULE20]
          nxt_st.tmr = 16'h0000;
          nxt_st.freq = i_run_freq; // [RULE19]
          if (i_running && restartable && {12'h000, st_ff.count} < st_ff.limit) begin
            nxt_st.state = FAM_ST_BASEBLOCK; // [RULE1]
          end else begin
            nxt_st.state = FAM_ST_PROTECT; // [RULE4]
          end
        end
      end
      FAM_ST_BASEBLOCK: begin
        if (st_ff.tmr >= i_min_baseblock_ms) begin
          nxt_st.tmr = 16'h0000;
          nxt_st.state = FAM_ST_RETRY;
        end else if (tick) begin
          nxt_st.tmr = st_ff.tmr + 16'h0001;
        end
      end
      FAM_ST_RETRY: begin
        if (tick) begin
          if (st_ff.tmr == 16'(RETRY_INTERVAL_MS - 1)) begin
            nxt_st.tmr = 16'h0000;
            nxt_st.clear_p = 1'b1; // [RULE2]
            nxt_st.state = FAM_ST_CHECK;
          end else begin
            nxt_st.tmr = st_ff.tmr + 16'h0001;
          end
        end
      end
      FAM_ST_CHECK: begin
        // fault gone and diagnosis clean: resume through speed search
        if (!trip_any && i_self_check_ok) begin
          nxt_st.count = st_ff.count + 4'h1; // [RULE3]
          nxt_st.search_p = 1'b1; // [RULE1]
          nxt_st.restarted = 1'b1;
          nxt_st.run_tmr = 32'h00000000;
          nxt_st.state = FAM_ST_RUN;
        end else begin
          nxt_st.state = FAM_ST_RETRY;
        end
      end
      FAM_ST_PROTECT: begin
        if (reset_edge) begin
          nxt_st.count = 4'h0; // [RULE10]
          nxt_st.restarted = 1'b0;
          nxt_st.clear_p = 1'b1;
          nxt_st.state = FAM_ST_RUN;
        end
      end
      default: begin
        nxt_st.state = FAM_ST_PROTECT;
      end
    endcase

    // registered outputs follow the next state
    nxt_st.restart_act = (nxt_st.state == FAM_ST_BASEBLOCK) ||
                         (nxt_st.state == FAM_ST_RETRY) || (nxt_st.state == FAM_ST_CHECK);
    nxt_st.coast = (nxt_st.state != FAM_ST_RUN); // [RULE12]
    nxt_st.fault_ct = (nxt_st.state == FAM_ST_PROTECT) ||
                      (nxt_st.restart_act && st_ff.fc_sel[0]); // [RULE8]
    nxt_st.minor = st_ff.fan_s2 && !st_ff.fan_sel[0]; // [RULE13]
    // derating only matters while the motor is kept running
    if (nxt_st.minor && i_running) begin
      nxt_st.rating = RATING_DERATED_PCT; // [RULE14]
      if (i_variable_torque) begin
        nxt_st.ovl_base = VT_FAN_BASE_S; // [RULE16]
        nxt_st.ovl_pct = VT_FAN_PEAK_PCT;
        nxt_st.ovl_peak = VT_FAN_PEAK_S;
      end else begin
        nxt_st.ovl_base = CT_FAN_BASE_S; // [RULE15]
        nxt_st.ovl_pct = CT_FAN_PEAK_PCT;
        nxt_st.ovl_peak = CT_FAN_PEAK_S;
      end
    end else begin
      nxt_st.rating = RATING_NORMAL_PCT;
      nxt_st.ovl_base = NORM_BASE_S;
      nxt_st.ovl_pct = NORM_PEAK_PCT;
      nxt_st.ovl_peak = NORM_PEAK_S;
    end
    nxt_st.contacts = nxt_contacts;
  end

  // power-up clears the restart count and the rest, except fan select and rating, which load their defaults
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      st_ff <= '0; // [RULE11]
      st_ff.state <= FAM_ST_RUN;
      st_ff.limit <= RST_RESTART_LIMIT;
      st_ff.fc_sel <= RST_RESTART_FC_SEL;
      st_ff.fan_sel <= RST_FAN_DETECT_SEL;
      st_ff.rating <= RATING_NORMAL_PCT;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_reg_rdata = st_ff.rdata;
  assign o_reg_ack = st_ff.ack;
  assign o_coast_stop = st_ff.coast;
  assign o_fault_clear = st_ff.clear_p;
  assign o_search_start = st_ff.search_p;
  assign o_search_freq = st_ff.freq;
  assign o_restart_active = st_ff.restart_act;
  assign o_fault_contact = st_ff.fault_ct;
  assign o_minor_fault = st_ff.minor;
  assign o_fan_warn_blink = st_ff.minor & blink; // [RULE13]
  assign o_fan_run = fan_run;
  assign o_rating_pct = st_ff.rating;
  assign o_ovl_base_s = st_ff.ovl_base;
  assign o_ovl_peak_pct = st_ff.ovl_pct;
  assign o_ovl_peak_s = st_ff.ovl_peak;
  assign o_contacts = st_ff.contacts;
  assign o_restart_count = st_ff.count;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);

  chk_trip_coasts: assert property ( // [RULE1]
    (st_ff.state == FAM_ST_RUN && i_running && trip_any) |=> st_ff.coast)
    else $error("trip while running did not stop the output");
  chk_retry_spacing: assert property ( // [RULE2]
    (st_ff.clear_p && st_ff.state == FAM_ST_CHECK) |->
      ($past(tick) && $past(st_ff.tmr) == 16'(RETRY_INTERVAL_MS - 1)))
    else $error("fault clear not on the retry interval");
  chk_count_step: assert property ( // [RULE3]
    st_ff.search_p |-> (st_ff.count == $past(st_ff.count) + 4'h1 && !st_ff.coast))
    else $error("restart did not step the count");
  chk_limit_held: assert property ( // [RULE4]
    st_ff.restart_act |-> ({12'h000, st_ff.count} < st_ff.limit))
    else $error("restart beyond the attempt limit");
  chk_other_trip: assert property ( // [RULE5]
    (st_ff.state == FAM_ST_RUN && (trip_eff & ~TRIP_RESTARTABLE) != '0) |=>
      st_ff.state == FAM_ST_PROTECT)
    else $error("unlisted trip did not protect");
  chk_uv_gate: assert property ( // [RULE6]
    (st_ff.state == FAM_ST_RUN && trip_eff == (TRIP_W'(1) << TRIP_BUS_UNDERVOLTAGE) &&
     i_ride_through_sel == 2'h0) |=> st_ff.state == FAM_ST_PROTECT)
    else $error("undervoltage restarted without ride-through");
  chk_restart_contact: assert property ( // [RULE7]
    (st_ff.restart_act && $past(i_contact_func[7:0]) == FUNC_RESTART_EN) |-> st_ff.contacts[0])
    else $error("restart enabled contact not set");
  chk_fault_contact: assert property ( // [RULE8]
    st_ff.restart_act |-> (st_ff.fault_ct == $past(st_ff.fc_sel[0])))
    else $error("fault contact wrong during restart");
  chk_reset_clears: assert property ( // [RULE10]
    (st_ff.state == FAM_ST_PROTECT && reset_edge) |=> (st_ff.count == 4'h0 ##1 !st_ff.coast))
    else $error("fault reset did not clear the count");
  chk_derate: assert property ( // [RULE14]
    (st_ff.minor && $past(st_ff.minor) && $past(i_running)) |-> st_ff.rating == RATING_DERATED_PCT)
    else $error("fan fault did not derate the current");

  cov_auto_restart: cover property (st_ff.search_p);
  cov_protect_reset: cover property (st_ff.state == FAM_ST_PROTECT ##1 st_ff.state == FAM_ST_RUN);
  cov_fan_minor: cover property (st_ff.minor && i_running);
endmodule
`default_nettype wire

// *** sim/fam_drive_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module fam_drive_model (
  input wire logic i_clock,         // control clock
  input wire logic i_rstn,          // async reset, active low
  input wire logic [15:0] i_inject, // trip causes to raise
  input wire logic i_stuck,         // fault survives clears
  input wire logic i_coast,         // gate block from manager
  input wire logic i_clear,         // fault clear pulse
  output logic [15:0] o_trip,       // detector levels
  output logic o_running,           // motor running
  output logic o_check_ok           // self-diagnosis clean
);
  logic [15:0] trip_ff;
  // clear acts at once so the check cycle already sees clean detectors
  assign o_trip = (i_clear && !i_stuck) ? 16'h0000 : trip_ff;
  assign o_check_ok = !i_stuck;
  // detectors latch; motor turns only while gates are enabled
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      trip_ff <= 16'h0000;
      o_running <= 1'b0;
    end else begin
      trip_ff <= o_trip | i_inject;
      o_running <= !i_coast;
    end
  end
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top import fam_pkg::*; ;
  logic clk = 0, rstn = 0, wr = 0, rd = 0, vt = 0, frst = 0, fan = 0, stuck = 0;
  logic [15:0] addr = 16'h0000, wd = 16'h0000, inj = 16'h0000, q, rdata, sfreq, trip;
  logic [1:0] rts = 2'h0;
  logic [39:0] cf = 40'h00003D101E;
  logic ack, coast, fclr, srch, ract, fcon, minor, fanrun, running, ck_ok, blnk;
  // frequency and baseblock time come from variables so they stay adjustable
  logic [15:0] rfreq = 16'h0123, bbms = 16'h0002;
  logic [7:0] rat, ob, op, os;
  logic [4:0] cts;
  logic [3:0] cnt;
  int num_errors = 0, cmp_count = 0, n;
  // address, write data, expected readback
  localparam logic [47:0] ROWS [5] = '{48'h049E_000F_000A, 48'h049E_0001_0001,
    48'h049F_0001_0001, 48'h04E2_0000_0000, 48'h0001_0005_0000};
  always #(CLK_PERIOD_NS / 2) clk = ~clk;
  // short counts keep the run brief
  fam_restart_mgr #(.TICK_CYCLES(4), .RUN_CLEAR_TICKS(20), .FAN_PERIOD_TICKS(20),
    .FAN_STOP_TICKS(3)) dut (
    .i_clock(clk), .i_rstn(rstn), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_wdata(wd), .o_reg_rdata(rdata), .o_reg_ack(ack), .i_trip_vec(trip),
    .i_running(running), .i_self_check_ok(ck_ok), .i_run_freq(rfreq),
    .i_min_baseblock_ms(bbms), .i_ride_through_sel(rts), .i_variable_torque(vt),
    .i_contact_func(cf), .i_fault_reset(frst), .i_fan_fault(fan), .o_coast_stop(coast),
    .o_fault_clear(fclr), .o_search_start(srch), .o_search_freq(sfreq),
    .o_restart_active(ract), .o_fault_contact(fcon), .o_minor_fault(minor),
    .o_fan_warn_blink(blnk), .o_fan_run(fanrun), .o_rating_pct(rat), .o_ovl_base_s(ob),
    .o_ovl_peak_pct(op), .o_ovl_peak_s(os), .o_contacts(cts), .o_restart_count(cnt));
  fam_drive_model u_drive (.i_clock(clk), .i_rstn(rstn), .i_inject(inj), .i_stuck(stuck),
    .i_coast(coast), .i_clear(fclr), .o_trip(trip), .o_running(running), .o_check_ok(ck_ok));
  // verdict, the single exit point
  task automatic tally_and_finish();
    if (num_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // sample one step after the edge so updates have landed
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // strobe is a one-cycle pulse; ack is waited for under a bound
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d);
    int k;
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wd <= d;
    tick(1);
    wr <= 1'b0;
    rd <= 1'b0;
    for (k = 0; ack !== 1'b1 && k < 8; k++) tick(1);
    if (k >= 8) num_errors++;
    if (k >= 8) tally_and_finish();
    q = rdata;
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [15:0] e);
    acc(1'b0, a, 16'h0000);
    chk(q, e);
  endtask
  // s 0 waits for a search start, 1 for a fault clear; n counts cycles
  task automatic wait_on(input int s);
    n = 0;
    do begin
      tick(1);
      n++;
    end while (((s == 0) ? srch : fclr) !== 1'b1 && n < 3000);
    if (n >= 3000) num_errors++;
    if (n >= 3000) tally_and_finish();
  endtask
  task automatic trip_go(input logic [15:0] b, input logic s);
    @(posedge clk);
    inj <= b;
    stuck <= s;
    @(posedge clk);
    inj <= 16'h0000;
    tick(1);
  endtask
  // finish a restart, or reset a protective trip from the pin
  task automatic recover();
    if (ract === 1'b1) wait_on(0);
    else begin
      @(posedge clk) frst <= 1'b1;
      wait_on(1);
      frst <= 1'b0;
    end
    tick(3);
  endtask
  task automatic do_reset();
    @(posedge clk) rstn <= 1'b0;
    tick(12);
    @(posedge clk) rstn <= 1'b1;
    tick(3);
  endtask
  initial begin
    do_reset();
    for (int i = 0; i < 5; i++) begin
      acc(1'b1, ROWS[i][47:32], ROWS[i][31:16]);
      rd_chk(ROWS[i][47:32], ROWS[i][15:0]);
    end
    do_reset();
    rd_chk(OFS_RESTART_LIMIT, 16'h0000);
    rd_chk(OFS_RESTART_FC_SEL, 16'h0000);
    rd_chk(OFS_FAN_DETECT_SEL, 16'h0001);
    chk(cnt, 16'h0000);
    acc(1'b1, OFS_RESTART_LIMIT, 16'h0001);
    acc(1'b1, OFS_RESTART_FC_SEL, 16'h0001);
    acc(1'b1, OFS_FAN_DETECT_SEL, 16'h0000);
    // self-check fails twice, so clear attempts repeat
    trip_go(16'h0001, 1'b1);
    chk({coast, ract, fcon, cts[0]}, 16'h000F);
    wait_on(1);
    wait_on(1);
    chk(n, 16'h0014);
    @(posedge clk) stuck <= 1'b0;
    wait_on(0);
    chk({coast, cnt}, 16'h0001);
    chk(sfreq, 16'h0123);
    tick(2);
    trip_go(16'h0002, 1'b0);
    chk({ract, fcon}, 16'h0001);
    recover();
    chk({coast, cnt}, 16'h0000);
    trip_go(16'h4000, 1'b0);
    chk({ract, fcon}, 16'h0001);
    recover();
    trip_go(16'h0010, 1'b0);
    chk({ract, fcon}, 16'h0001);
    recover();
    @(posedge clk) rts <= 2'h1;
    trip_go(16'h0010, 1'b0);
    chk({ract, fcon}, 16'h0003);
    recover();
    tick(70);
    chk(cnt, 16'h0001);
    tick(20);
    chk(cnt, 16'h0000);
    @(posedge clk) fan <= 1'b1;
    tick(8);
    chk({minor, coast, cts[2:1], rat}, {4'hB, 8'h50});
    chk({ob, op, os[3:0]}, 20'hB496F);
    @(posedge clk) vt <= 1'b1;
    tick(2);
    chk({ob, op, os[3:0]}, 20'h1E78A);
    n = 0;
    repeat (80) begin
      tick(1);
      if (fanrun === 1'b0) n++;
    end
    chk(n, 16'h000C);
    @(posedge clk) fan <= 1'b0;
    acc(1'b1, OFS_FAN_DETECT_SEL, 16'h0001);
    @(posedge clk) fan <= 1'b1;
    tick(6);
    chk({coast, minor, blnk}, 16'h0004);
    tally_and_finish();
  end
endmodule
`default_nettype wire
